// >>> src/qed_top.v
/*
 Quadrature decoder bank with APB register access and frame-end latches.
 Assumes pin lines are asynchronous and frame-done strobes are on pclk.
*/
`timescale 1ns/1ps
`include "qed_defs.vh"
// Functional notes
// R01: Two decoders, own settings, chosen by selector
// R02: Selector resets to decoder zero
// R03: Phases decoded into signed 32-bit counter
// R04: Only differential lines feed phase inputs
// R05: Software keeps phase A and B lines distinct
// R06: Forward: A leads counts up, lags down
// R07: Backward: A lags counts up, leads down
// R08: Preset source rising edge loads minus one
// R09: Line preset only for input-mode lines
// R10: Overflow source loads minus one past max
// R11: Target position reached loads minus one
// R12: Reverse step while positive loads minus one
// R13: Software keeps preset line off phase lines
// R14: Chosen stream frame end latches counter
// R15: Latch clear command zeroes frame-end latch
// R16: Latch takes counter at frame reception
// R17: Step scale sets counter amount per step
// R18: Six selectable trigger pulse output modes
// R19: Any-step mode pulses on every step; no pulse for a step in a position-clear or line-preset cycle
// R20: No repeated pulses while standing still
// R21: Position read gives counter, write clears
// R22: Counter and latch zero after reset
module qed_top #(
  parameter NUM_DECODERS = 2,
  parameter NUM_LINES = 20,
  parameter SEL_W = 1
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // I/O lines and their modes
  input wire [NUM_LINES-1:0] line_in,
  input wire [NUM_LINES-1:0] line_diff_mode,
  input wire [NUM_LINES-1:0] line_input_mode,
  // Frame complete strobes of streams 0 to 3
  input wire [3:0] stream_frame_done,
  // Trigger pulses to the timers
  output wire [NUM_DECODERS-1:0] trigger_pulse
);
  reg [SEL_W-1:0] decoder_select_reg;
  reg [31:0] prdata_reg;
  reg pready_reg;
  reg pslverr_reg;
  reg [31:0] rd_data;
  reg rd_err;

  wire [NUM_LINES-1:0] line_sync;
  wire [31:0] count_w [0:NUM_DECODERS-1];
  wire [31:0] latch_w [0:NUM_DECODERS-1];
  wire [4:0] pa_w [0:NUM_DECODERS-1];
  wire [4:0] pb_w [0:NUM_DECODERS-1];
  wire pol_w [0:NUM_DECODERS-1];
  wire [2:0] psrc_w [0:NUM_DECODERS-1];
  wire [4:0] pline_w [0:NUM_DECODERS-1];
  wire [2:0] stream_w [0:NUM_DECODERS-1];
  wire [15:0] scale_w [0:NUM_DECODERS-1];
  wire [2:0] mode_w [0:NUM_DECODERS-1];
  wire [31:0] target_w [0:NUM_DECODERS-1];
  wire [15:0] mult_w [0:NUM_DECODERS-1];

  // Completing access phase: write takes effect here
  wire access = psel & penable & pready_reg;
  wire wr_go = access & pwrite;

  // Pin filtering
  qed_sync #(
    .WIDTH(NUM_LINES)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(line_in),
    .dout(line_sync)
  );

  // Selector, limited to existing decoders
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      decoder_select_reg <= `QED_RST_SELECT; // R02
    end else if (wr_go && paddr == `QED_OFF_SELECT) begin
      if (pwdata[SEL_W-1:0] < NUM_DECODERS) begin
        decoder_select_reg <= pwdata[SEL_W-1:0]; // R01
      end
    end
  end

  genvar d;
  generate
    for (d = 0; d < NUM_DECODERS; d = d + 1) begin : g_dec
      reg [4:0] phase_a_line_select_reg;
      reg [4:0] phase_b_line_select_reg;
      reg count_polarity_reg;
      reg [2:0] preset_src_reg;
      reg [4:0] preset_line_reg;
      reg [2:0] stream_select_reg;
      reg [15:0] step_scale_reg;
      reg [2:0] pulse_mode_reg;
      reg [31:0] target_position_reg;
      reg [15:0] multiple_reg;
      reg [31:0] frame_end_latch_reg;
      reg [31:0] frame_end_latch_next;
      reg phase_a_lvl;
      reg phase_b_lvl;
      reg preset_lvl;
      reg frame_hit;
      wire mine = (decoder_select_reg == d); // R01
      wire wr_mine = wr_go & mine;
      wire clr_count = wr_mine & (paddr == `QED_OFF_POSITION);
      wire clr_latch = wr_mine & (paddr == `QED_OFF_FE_CLEAR);

      // Software settings of this decoder
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          phase_a_line_select_reg <= `QED_RST_LINE;
          phase_b_line_select_reg <= `QED_RST_LINE;
          count_polarity_reg <= `QED_RST_POLARITY;
          preset_src_reg <= `QED_RST_PRESET_SRC;
          preset_line_reg <= `QED_RST_LINE;
          stream_select_reg <= `QED_RST_STREAM;
          step_scale_reg <= `QED_RST_STEP_SCALE;
          pulse_mode_reg <= `QED_RST_OUT_MODE;
          target_position_reg <= `QED_RST_TARGET;
          multiple_reg <= `QED_RST_MULTIPLE;
        end else if (wr_mine) begin
          case (paddr)
            `QED_OFF_PHASE_A: phase_a_line_select_reg <= pwdata[4:0];
            `QED_OFF_PHASE_B: phase_b_line_select_reg <= pwdata[4:0];
            `QED_OFF_POLARITY: count_polarity_reg <= pwdata[0];
            `QED_OFF_PRESET: begin
              preset_src_reg <= pwdata[`QED_PRESET_SRC_MSB:`QED_PRESET_SRC_LSB];
              preset_line_reg <= pwdata[`QED_PRESET_LINE_MSB:`QED_PRESET_LINE_LSB];
            end
            `QED_OFF_STREAM: stream_select_reg <= pwdata[2:0];
            `QED_OFF_STEP_SCALE: step_scale_reg <= pwdata[15:0];
            `QED_OFF_OUT_MODE: pulse_mode_reg <= pwdata[2:0];
            `QED_OFF_TARGET: target_position_reg <= pwdata;
            `QED_OFF_MULTIPLE: multiple_reg <= pwdata[15:0];
            default: begin
            end
          endcase
        end
      end

      // Line routing into the decoder
      always @* begin
        phase_a_lvl = 1'b0;
        phase_b_lvl = 1'b0;
        preset_lvl = 1'b0;
        if (phase_a_line_select_reg < NUM_LINES) begin
          phase_a_lvl = line_sync[phase_a_line_select_reg] & line_diff_mode[phase_a_line_select_reg]; // R04
        end
        if (phase_b_line_select_reg < NUM_LINES) begin
          phase_b_lvl = line_sync[phase_b_line_select_reg] & line_diff_mode[phase_b_line_select_reg]; // R04
        end
        if (preset_line_reg < NUM_LINES) begin
          preset_lvl = line_sync[preset_line_reg] & line_input_mode[preset_line_reg]; // R09
        end
      end

      // Frame-end latch; capture wins over clear
      always @* begin
        case (stream_select_reg)
          3'h1: frame_hit = stream_frame_done[0];
          3'h2: frame_hit = stream_frame_done[1];
          3'h3: frame_hit = stream_frame_done[2];
          3'h4: frame_hit = stream_frame_done[3];
          default: frame_hit = 1'b0;
        endcase
        if (frame_hit) begin
          frame_end_latch_next = count_w[d]; // R14 R16
        end else if (clr_latch) begin
          frame_end_latch_next = 32'h00000000; // R15
        end else begin
          frame_end_latch_next = frame_end_latch_reg;
        end
      end

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          frame_end_latch_reg <= `QED_RST_COUNT; // R22
        end else begin
          frame_end_latch_reg <= frame_end_latch_next;
        end
      end

      qed_channel u_chan (
        .pclk(pclk),
        .presetn(presetn),
        .phase_a(phase_a_lvl),
        .phase_b(phase_b_lvl),
        .preset_line(preset_lvl),
        .count_polarity(count_polarity_reg),
        .preset_neg_one_source(preset_src_reg),
        .step_scale(step_scale_reg),
        .pulse_output_mode(pulse_mode_reg),
        .target_position(target_position_reg),
        .position_multiple(multiple_reg),
        .clear_count(clr_count),
        .position_count(count_w[d]),
        .trigger_pulse(trigger_pulse[d])
      );

      assign latch_w[d] = frame_end_latch_reg;
      assign pa_w[d] = phase_a_line_select_reg;
      assign pb_w[d] = phase_b_line_select_reg;
      assign pol_w[d] = count_polarity_reg;
      assign psrc_w[d] = preset_src_reg;
      assign pline_w[d] = preset_line_reg;
      assign stream_w[d] = stream_select_reg;
      assign scale_w[d] = step_scale_reg;
      assign mode_w[d] = pulse_mode_reg;
      assign target_w[d] = target_position_reg;
      assign mult_w[d] = multiple_reg;
    end
  endgenerate

  // Read mux for the selected decoder
  always @* begin
    rd_data = 32'h00000000;
    rd_err = 1'b0;
    case (paddr)
      `QED_OFF_SELECT: rd_data = {{(32-SEL_W){1'b0}}, decoder_select_reg};
      `QED_OFF_PHASE_A: rd_data = {27'h0000000, pa_w[decoder_select_reg]};
      `QED_OFF_PHASE_B: rd_data = {27'h0000000, pb_w[decoder_select_reg]};
      `QED_OFF_POLARITY: rd_data = {31'h00000000, pol_w[decoder_select_reg]};
      `QED_OFF_PRESET: rd_data = {19'h00000, pline_w[decoder_select_reg], 5'h00, psrc_w[decoder_select_reg]};
      `QED_OFF_STREAM: rd_data = {29'h00000000, stream_w[decoder_select_reg]};
      `QED_OFF_FE_LATCH: rd_data = latch_w[decoder_select_reg];
      `QED_OFF_FE_CLEAR: rd_data = 32'h00000000;
      `QED_OFF_STEP_SCALE: rd_data = {16'h0000, scale_w[decoder_select_reg]};
      `QED_OFF_OUT_MODE: rd_data = {29'h00000000, mode_w[decoder_select_reg]};
      `QED_OFF_TARGET: rd_data = target_w[decoder_select_reg];
      `QED_OFF_MULTIPLE: rd_data = {16'h0000, mult_w[decoder_select_reg]};
      `QED_OFF_POSITION: rd_data = count_w[decoder_select_reg]; // R21
      default: rd_err = 1'b1;
    endcase
  end

  // One wait state per transfer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else if (psel && penable && !pready_reg) begin
      prdata_reg <= pwrite ? 32'h00000000 : rd_data;
      pready_reg <= 1'b1;
      pslverr_reg <= rd_err;
    end else begin
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
endmodule

// >>> src/qed_defs.vh
/*
 Register offsets, field positions, reset values and encodings of the
 quadrature decoder. Assumes a 12-bit APB byte address and 32-bit data.
*/
`ifndef QED_DEFS_VH
`define QED_DEFS_VH

// Register byte offsets
`define QED_OFF_SELECT 12'h000
`define QED_OFF_PHASE_A 12'h004
`define QED_OFF_PHASE_B 12'h008
`define QED_OFF_POLARITY 12'h00C
`define QED_OFF_PRESET 12'h010
`define QED_OFF_STREAM 12'h014
`define QED_OFF_FE_LATCH 12'h018
`define QED_OFF_FE_CLEAR 12'h01C
`define QED_OFF_STEP_SCALE 12'h020
`define QED_OFF_OUT_MODE 12'h024
`define QED_OFF_TARGET 12'h028
`define QED_OFF_MULTIPLE 12'h02C
`define QED_OFF_POSITION 12'h030

// Field positions
`define QED_PRESET_SRC_LSB 0
`define QED_PRESET_SRC_MSB 2
`define QED_PRESET_LINE_LSB 8
`define QED_PRESET_LINE_MSB 12

// Reset values
`define QED_RST_SELECT 1'b0
`define QED_RST_LINE 5'h00
`define QED_RST_POLARITY 1'b0
`define QED_RST_PRESET_SRC 3'h0
`define QED_RST_STREAM 3'h0
`define QED_RST_STEP_SCALE 16'h0001
`define QED_RST_OUT_MODE 3'h2
`define QED_RST_TARGET 32'h00000000
`define QED_RST_MULTIPLE 16'h0001
`define QED_RST_COUNT 32'h00000000

// Preset-to-minus-one sources
`define QED_PSRC_NONE 3'h0
`define QED_PSRC_LINE 3'h1
`define QED_PSRC_OVERFLOW 3'h2
`define QED_PSRC_FIXED 3'h3
`define QED_PSRC_REV_POS 3'h4

// Pulse output modes
`define QED_MODE_FIXED 3'h0
`define QED_MODE_MULTIPLE 3'h1
`define QED_MODE_ANY 3'h2
`define QED_MODE_FWD 3'h3
`define QED_MODE_ANY_POS 3'h4
`define QED_MODE_FWD_POS 3'h5

`endif

// >>> src/qed_sync.v
/*
 Four-flop input filter for pin levels.
 Assumes asynchronous inputs; output follows once stages two and three agree.
*/
`timescale 1ns/1ps
module qed_sync #(
  parameter WIDTH = 20
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Levels
  input wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg s1_reg;
      reg s2_reg;
      reg s3_reg;
      reg out_reg;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
          out_reg <= 1'b0;
        end else begin
          s1_reg <= din[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            out_reg <= s3_reg;
          end
        end
      end
      assign dout[i] = out_reg;
    end
  endgenerate
endmodule

// >>> src/qed_channel.v
/*
 One quadrature decoder: step decode, position counter, presets, pulse.
 Assumes filtered phase and preset levels on pclk and settings held stable.
*/
`timescale 1ns/1ps
`include "qed_defs.vh"
module qed_channel (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Filtered levels
  input wire phase_a,
  input wire phase_b,
  input wire preset_line,
  // Settings
  input wire count_polarity,
  input wire [2:0] preset_neg_one_source,
  input wire [15:0] step_scale,
  input wire [2:0] pulse_output_mode,
  input wire [31:0] target_position,
  input wire [15:0] position_multiple,
  input wire clear_count,
  // Results
  output wire [31:0] position_count,
  output wire trigger_pulse
);
  reg a_prev_reg;
  reg b_prev_reg;
  reg line_prev_reg;
  reg [31:0] count_reg;
  reg [31:0] count_next;
  reg pulse_reg;
  reg pulse_next;
  reg [31:0] raw_step;
  reg [31:0] stepped;
  reg [31:0] mag;
  reg mult_hit;
  reg now_pos;

  wire step = (phase_a ^ a_prev_reg) ^ (phase_b ^ b_prev_reg);
  wire a_leads = phase_a ^ b_prev_reg;
  wire up = a_leads ^ count_polarity; // R06 R07
  wire [31:0] scale32 = {16'h0000, step_scale}; // R17
  wire [31:0] sum = count_reg + scale32;
  wire [31:0] dif = count_reg - scale32;
  wire ovf = ~count_reg[31] & sum[31];
  wire was_pos = ~count_reg[31] & (|count_reg);
  wire line_rise = preset_line & ~line_prev_reg & (preset_neg_one_source == `QED_PSRC_LINE);

  always @* begin
    raw_step = up ? sum : dif; // R03
    stepped = raw_step;
    if (up && ovf && preset_neg_one_source == `QED_PSRC_OVERFLOW) begin
      stepped = 32'hFFFFFFFF; // R10
    end
    if (!up && was_pos && preset_neg_one_source == `QED_PSRC_REV_POS) begin
      stepped = 32'hFFFFFFFF; // R12
    end
    if (raw_step == target_position && preset_neg_one_source == `QED_PSRC_FIXED) begin
      stepped = 32'hFFFFFFFF; // R11
    end
    mag = raw_step[31] ? (32'h00000000 - raw_step) : raw_step;
    mult_hit = (position_multiple != 16'h0000) && (raw_step != 32'h00000000) &&
      ((mag % {16'h0000, position_multiple}) == 32'h00000000);
    now_pos = ~raw_step[31] & (|raw_step);
    if (clear_count) begin
      count_next = 32'h00000000; // R21
    end else if (line_rise) begin
      count_next = 32'hFFFFFFFF; // R08 R09
    end else if (step) begin
      count_next = stepped;
    end else begin
      count_next = count_reg;
    end
    pulse_next = 1'b0;
    if (step && !clear_count && !line_rise) begin // R20
      case (pulse_output_mode) // R18
        `QED_MODE_FIXED: pulse_next = (raw_step == target_position);
        `QED_MODE_MULTIPLE: pulse_next = mult_hit;
        `QED_MODE_ANY: pulse_next = 1'b1; // R19
        `QED_MODE_FWD: pulse_next = up;
        `QED_MODE_ANY_POS: pulse_next = now_pos;
        `QED_MODE_FWD_POS: pulse_next = up & now_pos;
        default: pulse_next = 1'b0;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_prev_reg <= 1'b0;
      b_prev_reg <= 1'b0;
      line_prev_reg <= 1'b0;
      count_reg <= `QED_RST_COUNT; // R22
      pulse_reg <= 1'b0;
    end else begin
      a_prev_reg <= phase_a;
      b_prev_reg <= phase_b;
      line_prev_reg <= preset_line;
      count_reg <= count_next;
      pulse_reg <= pulse_next;
    end
  end

  assign position_count = count_reg;
  assign trigger_pulse = pulse_reg;
endmodule

// >>> bench/qed_encoder_model.sv
/*
 AB incremental encoder model driving two separate line levels.
 Assumes move() is called right after a rising pclk edge.
*/
`timescale 1ns/1ps
module qed_encoder_model (
  // Clock
  input wire pclk,
  // Phase levels
  output logic phase_a,
  output logic phase_b
);
  logic [1:0] pos_reg = 2'h0;
  // Sequence 00,10,11,01: phase A leads going up
  assign phase_a = pos_reg == 2'h1 || pos_reg == 2'h2;
  assign phase_b = pos_reg[1];
  // One step per count, gap cycles between steps
  task automatic move(input logic fwd, input int n, input int gap);
    repeat (n) begin
      pos_reg <= fwd ? pos_reg + 2'h1 : pos_reg - 2'h1;
      repeat (gap) @(posedge pclk);
    end
  endtask
endmodule

// >>> bench/qed_top_asserts.sv
/*
 Port checker for qed_top: APB answer timing and trigger pulses.
 Assumes one pclk domain with active-low presetn.
*/
`timescale 1ns/1ps
module qed_top_asserts #(
  parameter NUM_DECODERS = 2,
  parameter NUM_LINES = 20
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Lines and pulses
  input wire [NUM_LINES-1:0] line_in,
  input wire [NUM_LINES-1:0] line_diff_mode,
  input wire [NUM_DECODERS-1:0] trigger_pulse
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready not after one wait cycle");
  a_ready_once: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside answer");
  a_err_rzero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_still_quiet: assert property (($stable(line_in) && $stable(line_diff_mode) && !psel) [*8] |-> trigger_pulse == '0)
    else $error("trigger pulse while standing still");
  a_pulse_single: assert property (($stable(line_in) && $stable(line_diff_mode) && !psel) [*5] ##0 trigger_pulse[0] |=> !trigger_pulse[0])
    else $error("trigger pulse longer than one cycle");
endmodule
bind qed_top qed_top_asserts #(.NUM_DECODERS(NUM_DECODERS), .NUM_LINES(NUM_LINES)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .line_in(line_in),
  .line_diff_mode(line_diff_mode), .trigger_pulse(trigger_pulse));

// >>> bench/tb_quadrature_encoder_decoder.sv
/*
 Bench for qed_top, encoder model on lines 1 and 2.
 Assumes the design header is on the include path.
*/
`timescale 1ns/1ps
`include "qed_defs.vh"
module tb_quadrature_encoder_decoder;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [19:0] tb_line = 20'h0;
  logic [19:0] line_diff_mode = 20'h00006;
  logic [19:0] line_input_mode = 20'h0;
  logic [3:0] stream_frame_done = 4'h0;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire [1:0] trigger_pulse;
  wire enc_a;
  wire enc_b;
  wire [19:0] line_in = tb_line | {17'h0, enc_b, enc_a, 1'b0};
  int bad_count = 0;
  int comparisons = 0;
  int pulses = 0;
  int pulses1 = 0;
  always #25 pclk = ~pclk;
  always @(posedge pclk) if (trigger_pulse[0] === 1'b1) pulses <= pulses + 1;
  always @(posedge pclk) if (trigger_pulse[1] === 1'b1) pulses1 <= pulses1 + 1;
  qed_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_in(line_in), .line_diff_mode(line_diff_mode), .line_input_mode(line_input_mode),
    .stream_frame_done(stream_frame_done), .trigger_pulse(trigger_pulse));
  qed_encoder_model enc (.pclk(pclk), .phase_a(enc_a), .phase_b(enc_b));
  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 20) begin
      bad_count++;
      finish_test();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rchk(input string name, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(name, exp, r);
  endtask
  task automatic line5(input logic v);
    tb_line[5] <= v;
    repeat (12) @(posedge pclk);
  endtask
  task automatic frame(input int s);
    stream_frame_done <= 4'h1 << s;
    @(posedge pclk);
    stream_frame_done <= 4'h0;
    @(posedge pclk);
  endtask
  task automatic t_reset();
    rchk("select", `QED_OFF_SELECT, 32'h0);
    rchk("position", `QED_OFF_POSITION, 32'h0);
    rchk("latch", `QED_OFF_FE_LATCH, 32'h0);
    rchk("scale", `QED_OFF_STEP_SCALE, 32'h1);
    rchk("mode", `QED_OFF_OUT_MODE, {29'h0, `QED_MODE_ANY});
  endtask
  task automatic t_mode(input string name, input logic [2:0] m, input int up, input int exp);
    wr(`QED_OFF_OUT_MODE, {29'h0, m});
    pulses = 0;
    enc.move(1'b1, up, 12);
    enc.move(1'b0, 2 * up, 12);
    enc.move(1'b1, up, 12);
    chk(name, exp, pulses);
  endtask
  task automatic t_count();
    wr(`QED_OFF_PHASE_A, 32'h1);
    wr(`QED_OFF_PHASE_B, 32'h2);
    enc.move(1'b1, 4, 12);
    rchk("fwd up", `QED_OFF_POSITION, 32'h4);
    chk("pulses", 32'h4, pulses);
    enc.move(1'b0, 2, 20);
    rchk("fwd down", `QED_OFF_POSITION, 32'h2);
    wr(`QED_OFF_POLARITY, 32'h1);
    enc.move(1'b1, 3, 12);
    rchk("bwd down", `QED_OFF_POSITION, 32'hFFFFFFFF);
    enc.move(1'b0, 1, 12);
    rchk("bwd up", `QED_OFF_POSITION, 32'h0);
    wr(`QED_OFF_POLARITY, 32'h0);
    wr(`QED_OFF_OUT_MODE, {29'h0, `QED_MODE_FWD});
    pulses = 0;
    enc.move(1'b1, 1, 12);
    enc.move(1'b0, 1, 12);
    chk("fwd pulses", 32'h1, pulses);
    wr(`QED_OFF_MULTIPLE, 32'h3);
    wr(`QED_OFF_TARGET, 32'h2);
    t_mode("any pos pulses", `QED_MODE_ANY_POS, 2, 3);
    t_mode("fwd pos pulses", `QED_MODE_FWD_POS, 2, 2);
    t_mode("multiple pulses", `QED_MODE_MULTIPLE, 3, 2);
    t_mode("fixed pulses", `QED_MODE_FIXED, 2, 1);
    wr(`QED_OFF_OUT_MODE, {29'h0, `QED_MODE_ANY});
    line_diff_mode <= 20'h0;
    pulses = 0;
    enc.move(1'b1, 4, 12);
    rchk("single ended", `QED_OFF_POSITION, 32'h0);
    chk("no pulses", 32'h0, pulses);
    line_diff_mode <= 20'h00006;
  endtask
  task automatic t_scale();
    wr(`QED_OFF_STEP_SCALE, 32'h5);
    enc.move(1'b1, 2, 12);
    rchk("scaled up", `QED_OFF_POSITION, 32'hA);
    enc.move(1'b0, 1, 12);
    rchk("scaled down", `QED_OFF_POSITION, 32'h5);
    wr(`QED_OFF_STEP_SCALE, 32'h1);
  endtask
  task automatic t_presets();
    wr(`QED_OFF_PRESET, {29'h0, `QED_PSRC_REV_POS});
    enc.move(1'b0, 1, 12);
    rchk("rev positive", `QED_OFF_POSITION, 32'hFFFFFFFF);
    enc.move(1'b0, 1, 12);
    rchk("rev negative", `QED_OFF_POSITION, 32'hFFFFFFFE);
    wr(`QED_OFF_POSITION, 32'h1234);
    rchk("cleared", `QED_OFF_POSITION, 32'h0);
    wr(`QED_OFF_TARGET, 32'h3);
    wr(`QED_OFF_PRESET, {29'h0, `QED_PSRC_FIXED});
    enc.move(1'b1, 3, 12);
    rchk("at target", `QED_OFF_POSITION, 32'hFFFFFFFF);
    wr(`QED_OFF_POSITION, 32'h0);
    wr(`QED_OFF_PRESET, 32'h00000501);
    line5(1'b1);
    line5(1'b0);
    rchk("output line", `QED_OFF_POSITION, 32'h0);
    line_input_mode[5] <= 1'b1;
    line5(1'b1);
    rchk("line rise", `QED_OFF_POSITION, 32'hFFFFFFFF);
    wr(`QED_OFF_PRESET, {29'h0, `QED_PSRC_NONE});
    wr(`QED_OFF_POSITION, 32'h0);
    line5(1'b0);
    line5(1'b1);
    rchk("no source", `QED_OFF_POSITION, 32'h0);
  endtask
  task automatic t_latch();
    enc.move(1'b1, 2, 12);
    wr(`QED_OFF_STREAM, 32'h2);
    frame(0);
    rchk("other stream", `QED_OFF_FE_LATCH, 32'h0);
    frame(1);
    enc.move(1'b1, 1, 12);
    rchk("latched", `QED_OFF_FE_LATCH, 32'h2);
    wr(`QED_OFF_FE_CLEAR, 32'h1);
    rchk("latch clear", `QED_OFF_FE_LATCH, 32'h0);
  endtask
  task automatic t_banks();
    logic [31:0] r;
    logic e;
    enc.move(1'b1, 3, 12);
    wr(`QED_OFF_SELECT, 32'h1);
    rchk("bank one", `QED_OFF_POSITION, 32'h0);
    wr(`QED_OFF_PHASE_A, 32'h1);
    wr(`QED_OFF_PHASE_B, 32'h2);
    wr(`QED_OFF_POLARITY, 32'h1);
    enc.move(1'b1, 2, 12);
    rchk("bank one count", `QED_OFF_POSITION, 32'hFFFFFFFE);
    chk("bank one pulses", 32'h2, pulses1);
    wr(`QED_OFF_SELECT, 32'h0);
    rchk("bank zero", `QED_OFF_POSITION, 32'h8);
    apb(1'b0, 12'h040, 32'h0, r, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, r);
  endtask
  initial begin
    repeat (30000) @(posedge pclk);
    bad_count++;
    finish_test();
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_count();
    t_scale();
    t_presets();
    t_latch();
    t_banks();
    finish_test();
  end
endmodule
